// *** fpc_pkg.sv ***
// shared constants, types and pin carrier for the flash program/erase controller
package fpc_pkg;
	localparam int          CLK_PERIOD_NS  = 4;
	localparam int          ADDR_W         = 19;
	localparam int          DATA_W         = 16;
	// software register offsets
	localparam logic [3:0]  REG_CMD        = 4'h0;
	localparam logic [3:0]  REG_ADDR       = 4'h1;
	localparam logic [3:0]  REG_DATA       = 4'h2;
	localparam logic [3:0]  REG_CTRL       = 4'h3;
	localparam logic [3:0]  REG_STATUS     = 4'h4;
	localparam logic [3:0]  REG_RDATA      = 4'h5;
	// status field positions
	localparam int          ST_BUSY        = 0;
	localparam int          ST_DONE        = 1;
	localparam int          ST_REFUSED     = 2;
	localparam int          ST_TIMEOUT     = 3;
	localparam int          ST_VERIFY      = 4;
	localparam int          ST_LOCKED      = 5;
	localparam int          ST_SUSPENDED   = 6;
	localparam int          ST_CORRUPT     = 7;
	localparam int          ST_PWR_OK      = 8;
	localparam int          ST_SUSP_TGL    = 9;
	localparam int          ST_RDY_PIN     = 10;
	localparam int          ST_W           = 11;
	localparam logic [10:0] ST_W1C_MASK    = 11'h2BE;
	localparam int          CTRL_HV_BIT    = 0;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	// bus cycle timing, as printed in ns, and cycles derived (least: round up)
	localparam int          T_SETUP_NS     = 20;
	localparam int          T_WE_LOW_NS    = 40;
	localparam int          T_READ_NS      = 80;
	localparam int          T_HOLD_NS      = 20;
	localparam int          T_RESET_NS     = 50;
	localparam int          T_SUSPEND_NS   = 15000;
	localparam int          SETUP_CYC      = (T_SETUP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int          WE_CYC         = (T_WE_LOW_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int          RD_CYC         = (T_READ_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int          HOLD_CYC       = (T_HOLD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int          RESET_CYC      = (T_RESET_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int          SUSPEND_CYC    = (T_SUSPEND_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int          T_PWRON_MS     = 10;
	localparam int          PWRON_CYC      = T_PWRON_MS * 1000000
		/ CLK_PERIOD_NS;
	localparam int          POLL_LIMIT     = 1000000;
	// command words
	localparam logic [18:0] UNLOCK_A1      = 19'h05555;
	localparam logic [18:0] UNLOCK_A2      = 19'h02AAA;
	localparam logic [15:0] CD_AA          = 16'h00AA;
	localparam logic [15:0] CD_55          = 16'h0055;
	localparam logic [15:0] CD_ERASE_SETUP = 16'h0080;
	localparam logic [15:0] CD_PROGRAM     = 16'h00A0;
	localparam logic [15:0] CD_CHIP_ERASE  = 16'h0010;
	localparam logic [15:0] CD_SECT_ERASE  = 16'h0030;
	localparam logic [15:0] CD_LOCKOUT     = 16'h0040;
	localparam logic [15:0] CD_SUSPEND     = 16'h00B0;
	localparam logic [15:0] CD_RESUME      = 16'h0030;
	localparam logic [15:0] CD_ID_ENTRY    = 16'h0090;
	localparam logic [15:0] CD_ID_EXIT     = 16'h00F0;
	localparam logic [18:0] LOCK_OFFSET    = 19'h00002;
	localparam int          LOCK_FLAG_POS  = 0;
	localparam int          POLL_POS       = 7;
	localparam int          TOGGLE_POS     = 6;
	localparam int          SUSP_TGL_POS   = 2;
	localparam int          PLANE_LSB      = 16;

	typedef enum logic [3:0] {
		OP_READ       = 4'h0,
		OP_PROGRAM    = 4'h1,
		OP_SECT_ERASE = 4'h2,
		OP_CHIP_ERASE = 4'h3,
		OP_LOCKOUT    = 4'h4,
		OP_SUSPEND    = 4'h5,
		OP_RESUME     = 4'h6,
		OP_LOCK_QUERY = 4'h7,
		OP_ID_EXIT    = 4'h8,
		OP_RESET      = 4'h9
	} fpc_op_t;

	typedef struct packed {
		logic [18:0] addr;
		logic [15:0] dq_o;
		logic        dq_oe;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
	} fpc_pins_t;
endpackage : fpc_pkg

// *** fpc_bus_cycle.sv ***
// one strobed write or read cycle on the flash parallel bus
`timescale 1ns/10ps
module fpc_bus_cycle
	import fpc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        en,
	input  wire logic        start,
	input  wire logic        wr,
	input  wire logic [18:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] dq_i,
	output logic             done,
	output logic [15:0]      rdata,
	output fpc_pins_t        pins
);
	typedef enum logic [3:0] {
		C_IDLE   = 4'b0001,
		C_SETUP  = 4'b0010,
		C_STROBE = 4'b0100,
		C_HOLD   = 4'b1000
	} fpc_cyc_t;

	fpc_cyc_t  state_q;
	logic [4:0] cnt_q;
	logic      wr_q;
	logic      done_q;
	logic [15:0] rdata_q;
	fpc_pins_t pins_q;

	if (WE_CYC > 31 || RD_CYC > 31 || SETUP_CYC > 31 || HOLD_CYC > 31)
	begin : g_chk
		$error("bus cycle counts exceed counter width");
	end

	// oe_n stays high through any write phase, so no write is inhibited
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= C_IDLE;
			cnt_q   <= 5'h00;
			wr_q    <= 1'b0;
			done_q  <= 1'b0;
			pins_q  <= '{addr: 19'h00000, dq_o: 16'h0000, dq_oe: 1'b0,
				ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
		end
		else if (en)
		begin
			done_q <= 1'b0;
			case (state_q)
				C_IDLE:
					if (start)
					begin
						pins_q.addr  <= addr;
						pins_q.dq_o  <= wdata;
						pins_q.dq_oe <= wr;
						pins_q.ce_n  <= 1'b0;
						wr_q         <= wr;
						cnt_q        <= 5'(SETUP_CYC - 1);
						state_q      <= C_SETUP;
					end
				C_SETUP:
					if (cnt_q == 5'h00)
					begin
						pins_q.we_n <= ~wr_q;
						pins_q.oe_n <= wr_q;
						cnt_q   <= wr_q ? 5'(WE_CYC - 1) : 5'(RD_CYC - 1);
						state_q <= C_STROBE;
					end
					else
						cnt_q <= cnt_q - 5'h01;
				C_STROBE:
					if (cnt_q == 5'h00)
					begin
						pins_q.we_n <= 1'b1;
						pins_q.oe_n <= 1'b1;
						cnt_q       <= 5'(HOLD_CYC - 1);
						state_q     <= C_HOLD;
					end
					else
						cnt_q <= cnt_q - 5'h01;
				C_HOLD:
					if (cnt_q == 5'h00)
					begin
						pins_q.ce_n  <= 1'b1;
						pins_q.dq_oe <= 1'b0;
						done_q       <= 1'b1;
						state_q      <= C_IDLE;
					end
					else
						cnt_q <= cnt_q - 5'h01;
				default:
					state_q <= C_IDLE;
			endcase
		end
	end

	// read data sampled as the output gate is released
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_q <= 16'h0000;
		else if (en && state_q == C_STROBE && cnt_q == 5'h00 && !wr_q)
			rdata_q <= dq_i;
	end

	assign done  = done_q;
	assign rdata = rdata_q;
	assign pins  = pins_q;
endmodule : fpc_bus_cycle

// *** fpc_flash_ctrl.sv ***
// host-side program/erase sequencer for an eight-plane parallel flash
`timescale 1ns/10ps
// Contract
// - program is four command writes; device then times its own pulses
// - host enables sector lockout with a six-write sequence naming sector
// - host issues id-exit after checking lock state
// - resume is one write carrying plane on top three address bits
module fpc_flash_ctrl
	import fpc_pkg::*;
#(
	parameter int PWRON_CYCLES = PWRON_CYC,
	parameter int POLL_CYCLES  = POLL_LIMIT
)(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        en,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	output fpc_pins_t        flash,
	input  wire logic [15:0] flash_dq_i,
	output logic             flash_reset_n,
	output logic             flash_hv_override,
	input  wire logic        flash_rdy_i
);
	typedef enum logic [6:0] {
		S_IDLE    = 7'b0000001,
		S_WRITE   = 7'b0000010,
		S_POLL    = 7'b0000100,
		S_SUSPWT  = 7'b0001000,
		S_LQREAD  = 7'b0010000,
		S_RDPAIR  = 7'b0100000,
		S_RSTLOW  = 7'b1000000
	} fpc_state_t;

	fpc_state_t  state_q;
	fpc_op_t     op_q;
	logic [18:0] addr_q;
	logic [15:0] data_q;
	logic [15:0] ctrl_q;
	logic [15:0] rdata_q;
	logic [15:0] reg_rdata_q;
	logic [15:0] prev_q;
	logic        have_prev_q;
	logic [2:0]  step_q;
	logic [2:0]  nsteps;
	logic [21:0] cnt_q;
	logic [21:0] pwr_cnt_q;
	logic        pwr_ok_q;
	logic        issue_q;
	logic [10:0] st_q;
	logic [10:0] st_set;
	logic [10:0] st_clr;
	logic        cyc_done;
	logic [15:0] cyc_rdata;
	logic        cyc_wr;
	logic [18:0] cyc_addr;
	logic [15:0] cyc_data;
	logic        go;
	fpc_op_t     go_op;
	logic        refuse;
	logic        is_long;
	logic        toggled;
	logic        susp_ok;
	logic        susp_req_q;
	logic        cyc_act_q;

	if (PWRON_CYCLES < 1 || PWRON_CYCLES > 22'h3FFFFF ||
		POLL_CYCLES < 2 || POLL_CYCLES > 22'h3FFFFF || SUSPEND_CYC > 22'h3FFFFF)
	begin : g_chk
		$error("count parameter out of range");
	end

	// command word for the current step; sector commands take any address
	// inside the sector, so the user address passes through untouched
	function automatic logic [34:0] cmd_word(fpc_op_t op, logic [2:0] step,
		logic [18:0] a, logic [15:0] d);
		logic [15:0] third;
		third = CD_ERASE_SETUP;
		if (op == OP_PROGRAM)
			third = CD_PROGRAM;
		else if (op == OP_LOCK_QUERY)
			third = CD_ID_ENTRY;
		case (step)
			3'd0: cmd_word = {UNLOCK_A1, CD_AA};
			3'd1: cmd_word = {UNLOCK_A2, CD_55};
			3'd2: cmd_word = {UNLOCK_A1, third};
			3'd3: cmd_word = (op == OP_PROGRAM) ? {a, d} : {UNLOCK_A1, CD_AA};
			3'd4: cmd_word = {UNLOCK_A2, CD_55};
			3'd5:
				case (op)
					OP_CHIP_ERASE: cmd_word = {UNLOCK_A1, CD_CHIP_ERASE};
					OP_SECT_ERASE: cmd_word = {a, CD_SECT_ERASE};
					default:       cmd_word = {a, CD_LOCKOUT};
				endcase
			default: cmd_word = {UNLOCK_A1, CD_AA};
		endcase
	endfunction : cmd_word

	always_comb
	begin
		case (op_q)
			OP_PROGRAM:    nsteps = 3'd4;
			OP_LOCK_QUERY: nsteps = 3'd3;
			OP_SECT_ERASE,
			OP_CHIP_ERASE,
			OP_LOCKOUT:    nsteps = 3'd6;
			default:       nsteps = 3'd1;
		endcase
	end

	always_comb
	begin
		cyc_wr   = 1'b1;
		cyc_addr = 19'h00000;
		cyc_data = 16'h0000;
		case (state_q)
			S_WRITE:
				case (op_q)
					OP_SUSPEND: cyc_data = CD_SUSPEND;
					OP_RESUME:
					begin
						cyc_addr = {addr_q[18:PLANE_LSB], 16'h0000};
						cyc_data = CD_RESUME;
					end
					OP_ID_EXIT,
					OP_READ:    cyc_data = CD_ID_EXIT;
					default:    {cyc_addr, cyc_data} =
						cmd_word(op_q, step_q, addr_q, data_q);
				endcase
			S_LQREAD:
			begin
				cyc_wr   = 1'b0;
				cyc_addr = addr_q | LOCK_OFFSET;
			end
			default:
			begin
				cyc_wr   = 1'b0;
				cyc_addr = addr_q;
			end
		endcase
	end

	assign go      = en && reg_wr && reg_addr == REG_CMD;
	assign go_op   = fpc_op_t'(reg_wdata[3:0]);
	assign is_long = go_op == OP_PROGRAM || go_op == OP_SECT_ERASE ||
		go_op == OP_CHIP_ERASE || go_op == OP_LOCKOUT;
	// busy refuses all but reset, which aborts, and suspend of an erase
	assign susp_ok = go_op == OP_SUSPEND && state_q == S_POLL &&
		(op_q == OP_SECT_ERASE || op_q == OP_CHIP_ERASE);
	assign refuse  = go && go_op != OP_RESET &&
		((st_q[ST_BUSY] && !susp_ok) ||
		(is_long && !pwr_ok_q) ||
		(st_q[ST_SUSPENDED] && (go_op == OP_SECT_ERASE ||
		go_op == OP_CHIP_ERASE)) || go_op > OP_RESET);
	assign toggled = have_prev_q &&
		(prev_q[TOGGLE_POS] != cyc_rdata[TOGGLE_POS]);

	fpc_bus_cycle u_cycle (
		.clk    (clk),
		.arst_n (arst_n),
		.en     (en),
		.start  (issue_q),
		.wr     (cyc_wr),
		.addr   (cyc_addr),
		.wdata  (cyc_data),
		.dq_i   (flash_dq_i),
		.done   (cyc_done),
		.rdata  (cyc_rdata),
		.pins   (flash)
	);

	// a suspend waits for the poll read under way before it takes the bus
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			susp_req_q <= 1'b0;
		else if (en)
			susp_req_q <= state_q == S_POLL && (susp_req_q || (go && susp_ok));
	end

	// reset waits for a cut cycle to end, so its done is never taken stale
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cyc_act_q <= 1'b0;
		else if (en)
			cyc_act_q <= issue_q || (cyc_act_q && !cyc_done);
	end

	// power-on wait before any program or erase is offered
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pwr_cnt_q <= 22'h000000;
			pwr_ok_q  <= 1'b0;
		end
		else if (en && !pwr_ok_q)
		begin
			pwr_cnt_q <= pwr_cnt_q + 22'h000001;
			pwr_ok_q  <= pwr_cnt_q == 22'(PWRON_CYCLES - 1);
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q     <= S_IDLE;
			op_q        <= OP_READ;
			step_q      <= 3'd0;
			cnt_q       <= 22'h000000;
			issue_q     <= 1'b0;
			prev_q      <= 16'h0000;
			have_prev_q <= 1'b0;
			rdata_q     <= 16'h0000;
			st_set      <= 11'h000;
		end
		else if (en)
		begin
			issue_q <= 1'b0;
			st_set  <= 11'h000;
			if (go && go_op == OP_RESET)
			begin
				// a program cut short leaves its word undefined
				st_set[ST_CORRUPT] <= state_q == S_POLL &&
					op_q == OP_PROGRAM;
				op_q    <= OP_RESET;
				cnt_q   <= 22'(RESET_CYC - 1);
				state_q <= S_RSTLOW;
			end
			else if (refuse)
				st_set[ST_REFUSED] <= 1'b1;
			else
				case (state_q)
					S_IDLE:
						if (go)
						begin
							op_q        <= go_op;
							step_q      <= 3'd0;
							have_prev_q <= 1'b0;
							issue_q     <= 1'b1;
							state_q     <= go_op == OP_READ ? S_RDPAIR : S_WRITE;
						end
					S_WRITE:
						if (cyc_done)
						begin
							if (step_q != nsteps - 3'd1)
							begin
								step_q  <= step_q + 3'd1;
								issue_q <= 1'b1;
							end
							else if (op_q == OP_LOCK_QUERY)
							begin
								issue_q <= 1'b1;
								state_q <= S_LQREAD;
							end
							else if (op_q == OP_SUSPEND)
							begin
								cnt_q   <= 22'(SUSPEND_CYC - 1);
								state_q <= S_SUSPWT;
							end
							else if (op_q == OP_READ || op_q == OP_ID_EXIT ||
								op_q == OP_RESUME)
							begin
								st_set[ST_DONE] <= 1'b1;
								state_q <= op_q == OP_RESUME ? S_POLL : S_IDLE;
								cnt_q   <= 22'(POLL_CYCLES - 1);
								issue_q <= op_q == OP_RESUME;
							end
							else
							begin
								cnt_q   <= 22'(POLL_CYCLES - 1);
								issue_q <= 1'b1;
								state_q <= S_POLL;
							end
						end
					S_POLL:
						if (cyc_done)
						begin
							prev_q      <= cyc_rdata;
							have_prev_q <= 1'b1;
							rdata_q     <= cyc_rdata;
							if (susp_req_q)
							begin
								op_q    <= OP_SUSPEND;
								step_q  <= 3'd0;
								issue_q <= 1'b1;
								state_q <= S_WRITE;
							end
							// two reads with the toggle bit unchanged and the line released end it
							else if (have_prev_q && !toggled &&
								flash_rdy_i)
							begin
								st_set[ST_DONE] <= 1'b1;
								st_set[ST_VERIFY] <= (op_q == OP_PROGRAM &&
									cyc_rdata != data_q) ||
									(op_q == OP_SECT_ERASE &&
									cyc_rdata != 16'hFFFF);
								state_q <= S_IDLE;
							end
							else if (cnt_q == 22'h000000)
							begin
								st_set[ST_TIMEOUT] <= 1'b1;
								state_q <= S_IDLE;
							end
							else
								issue_q <= 1'b1;
						end
						else if (cnt_q != 22'h000000)
							cnt_q <= cnt_q - 22'h000001;
					S_SUSPWT:
						if (cnt_q == 22'h000000)
						begin
							st_set[ST_DONE] <= 1'b1;
							state_q <= S_IDLE;
						end
						else
							cnt_q <= cnt_q - 22'h000001;
					S_LQREAD:
						if (cyc_done)
						begin
							rdata_q <= cyc_rdata;
							op_q    <= OP_ID_EXIT;
							step_q  <= 3'd0;
							issue_q <= 1'b1;
							state_q <= S_WRITE;
						end
					S_RDPAIR:
						if (cyc_done)
						begin
							prev_q      <= cyc_rdata;
							have_prev_q <= 1'b1;
							rdata_q     <= cyc_rdata;
							if (have_prev_q)
							begin
								st_set[ST_SUSP_TGL] <= prev_q[SUSP_TGL_POS] !=
									cyc_rdata[SUSP_TGL_POS];
								st_set[ST_DONE] <= 1'b1;
								state_q <= S_IDLE;
							end
							else
								issue_q <= 1'b1;
						end
					S_RSTLOW:
						if (cnt_q != 22'h000000)
							cnt_q <= cnt_q - 22'h000001;
						else if (!cyc_act_q)
						begin
							st_set[ST_DONE] <= 1'b1;
							state_q <= S_IDLE;
						end
					default:
						state_q <= S_IDLE;
				endcase
		end
	end

	// busy, suspended, power and ready pin are tracked states, locked follows each lock query, the rest are sticky events
	assign st_clr = (en && reg_wr && reg_addr == REG_STATUS) ?
		(reg_wdata[10:0] & ST_W1C_MASK) : 11'h000;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st_q <= 11'h000;
		else if (en)
		begin
			st_q <= (st_q & ~st_clr) | (st_set & ST_W1C_MASK); // set wins
			st_q[ST_BUSY]    <= state_q != S_IDLE || issue_q ||
				(go && !refuse);
			st_q[ST_PWR_OK]  <= pwr_ok_q;
			st_q[ST_RDY_PIN] <= flash_rdy_i;
			if (state_q == S_LQREAD && cyc_done)
				st_q[ST_LOCKED] <= cyc_rdata[LOCK_FLAG_POS];
			if (state_q == S_SUSPWT && cnt_q == 22'h000000)
				st_q[ST_SUSPENDED] <= 1'b1;
			else if ((state_q == S_WRITE && op_q == OP_RESUME && cyc_done) ||
				state_q == S_RSTLOW)
				st_q[ST_SUSPENDED] <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			addr_q <= 19'h00000;
			data_q <= 16'h0000;
			ctrl_q <= CTRL_RESET;
		end
		else if (en && reg_wr)
		begin
			if (reg_addr == REG_ADDR && state_q == S_IDLE)
				addr_q[15:0] <= reg_wdata;
			if (reg_addr == REG_DATA && state_q == S_IDLE)
				data_q <= reg_wdata;
			if (reg_addr == REG_CTRL)
			begin
				ctrl_q <= reg_wdata;
				if (state_q == S_IDLE)
					addr_q[18:16] <= reg_wdata[15:13];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata_q <= 16'h0000;
		else if (en && reg_rd)
			case (reg_addr)
				REG_ADDR:   reg_rdata_q <= addr_q[15:0];
				REG_DATA:   reg_rdata_q <= data_q;
				REG_CTRL:   reg_rdata_q <= ctrl_q;
				REG_STATUS: reg_rdata_q <= {5'h00, st_q};
				REG_RDATA:  reg_rdata_q <= rdata_q;
				default:    reg_rdata_q <= 16'h0000;
			endcase
	end

	assign reg_rdata         = reg_rdata_q;
	assign flash_reset_n     = state_q != S_RSTLOW;
	assign flash_hv_override = ctrl_q[CTRL_HV_BIT];
endmodule : fpc_flash_ctrl

// *** fpc_flash_ctrl_properties.sv ***
// assertions on the flash controller pins
`timescale 1ns/10ps
module fpc_flash_ctrl_checker
	import fpc_pkg::*;
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        en,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire fpc_pins_t   flash,
	input wire logic        flash_reset_n,
	input wire logic        flash_hv_override
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_WE_NEEDS_SELECT:
		assert property (!flash.we_n |-> !flash.ce_n && flash.oe_n)
		else $error("write strobe outside a selected write");
	AST_NO_DRIVE_ON_READ:
		assert property (!flash.oe_n |-> !flash.dq_oe)
		else $error("data driven while output gate low");
	AST_DRIVE_ON_WRITE:
		assert property (!flash.we_n |-> flash.dq_oe)
		else $error("write strobe without driven data");
	AST_WE_WIDE:
		assert property ($fell(flash.we_n) |-> !flash.we_n [*8])
		else $error("write strobe pulse too short");
	AST_CE_HOLD:
		assert property ($rose(flash.we_n) |-> !flash.ce_n [*4])
		else $error("select released too soon after strobe");
	AST_ADDR_STEADY:
		assert property (!flash.ce_n && !$past(flash.ce_n)
			|-> $stable(flash.addr))
		else $error("address moved during a bus cycle");
	AST_RESET_WIDE:
		assert property ($fell(flash_reset_n) |-> !flash_reset_n [*8])
		else $error("flash reset pulse too short");
	AST_HV_FROM_CTRL:
		assert property (en && reg_wr && reg_addr == REG_CTRL
			|=> flash_hv_override == $past(reg_wdata[CTRL_HV_BIT]))
		else $error("override level does not follow control");
	COV_WRITE: cover property ($rose(flash.we_n));
	COV_READ: cover property ($rose(flash.oe_n));
	COV_RESET: cover property ($rose(flash_reset_n));
endmodule : fpc_flash_ctrl_checker

bind fpc_flash_ctrl fpc_flash_ctrl_checker u_chk (
	.clk(clk), .arst_n(arst_n), .en(en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .flash(flash),
	.flash_reset_n(flash_reset_n), .flash_hv_override(flash_hv_override)
);

// *** fpc_flash_model.sv ***
// behavioural flash device facing the controller pins
`timescale 1ns/10ps
module fpc_flash_model
	import fpc_pkg::*;
#(
	parameter int PROG_NS  = 300,
	parameter int ERASE_NS = 1200,
	parameter int SUSP_NS  = 400,
	parameter int PWRON_NS = 150
)(
	input  wire fpc_pins_t pins,
	input  wire logic      reset_n,
	input  wire logic      hv,
	output logic [15:0]    dq,
	output logic           busy_pull
);
	logic [15:0] mem [int];
	logic [15:0] lock = '0; // coarse map: one flag per 32K words
	logic [15:0] ld, lastq = '0;
	logic [18:0] la, a_q;
	logic        pm = 0, idm = 0, prog = 0, ers = 0, susp = 0, halt = 0;
	logic        tgl = 0, pwr = 0;
	int          step = 0, es = 0, gen = 0;
	function automatic int sec(logic [18:0] a);
		return int'(a[18:15]);
	endfunction : sec
	function automatic logic [15:0] rdw(logic [18:0] a);
		return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
	endfunction : rdw
	task automatic finish_op();
		if (halt)
		begin
			halt = 0;
			susp = 1;
			return;
		end
		if (prog)
			mem[int'(la)] = rdw(la) & ld;
		if (ers)
			foreach (mem[k])
				if ((es < 0 || sec(19'(k)) == es) && (!lock[sec(19'(k))] || hv))
					mem[k] = 16'hFFFF;
		prog = 0;
		ers = 0;
	endtask : finish_op
	// a newer start or a reset makes a pending timer stale
	task automatic run(int ns);
		int g;
		gen++;
		g = gen;
		fork
			begin
				#(ns);
				if (g == gen)
					finish_op();
			end
		join_none
	endtask : run
	task automatic command(logic [18:0] a, logic [15:0] w);
		logic [7:0] d;
		logic       ok;
		d = w[7:0];
		if (prog || halt || (ers && !susp && d != 8'hB0))
			return;
		if (d == 8'hB0)
		begin
			if (ers && !susp)
			begin
				halt = 1;
				run(SUSP_NS);
			end
			return;
		end
		if (step == 0 && d == 8'h30 && susp && (es < 0 || a[18:16] == 3'(es >> 1)))
		begin
			susp = 0;
			run(ERASE_NS);
			return;
		end
		if (step == 0 && d == 8'hF0)
			idm = 0;
		if (step == 3 && pm)
		begin
			step = 0;
			pm = 0;
			if (pwr && (!lock[sec(a)] || hv))
			begin
				la = a;
				ld = w;
				prog = 1;
				run(PROG_NS);
			end
			return;
		end
		case (step)
			0, 3: ok = a[15:0] == 16'h5555 && d == 8'hAA;
			1, 4: ok = a[15:0] == 16'h2AAA && d == 8'h55;
			2: ok = a[15:0] == 16'h5555;
			default: ok = 1;
		endcase
		step = ok ? step + 1 : 0;
		if (step == 3)
		begin
			pm = d == 8'hA0;
			idm = idm || d == 8'h90;
			if (d != 8'h80 && !pm)
				step = 0;
		end
		if (step == 6)
		begin
			step = 0;
			if (d == 8'h40)
				lock[sec(a)] = 1;
			else if ((d == 8'h10 || d == 8'h30) && !susp)
			begin
				es = d == 8'h10 ? -1 : sec(a);
				ers = 1;
				run(ERASE_NS);
			end
		end
	endtask : command
	initial
		#(PWRON_NS) pwr = 1;
	always @(negedge pins.we_n)
		a_q = pins.addr;
	always @(posedge pins.we_n)
		if (!pins.ce_n && pins.oe_n && reset_n)
			command(a_q, pins.dq_o);
	always @(negedge reset_n)
	begin
		gen++;
		if (prog)
			mem[int'(la)] = ~ld;
		{pm, idm, prog, ers, susp, halt} = '0;
		step = 0;
	end
	always @(negedge pins.oe_n)
		tgl = ~tgl;
	// a released bus shows the inverse, never a stale copy
	always @*
	begin
		dq = ~lastq;
		if (!pins.ce_n && !pins.oe_n && pins.we_n && reset_n)
		begin
			dq = rdw(pins.addr);
			if (idm && pins.addr[14:0] == 15'h2)
				dq = {15'h0, lock[sec(pins.addr)]};
			if (prog && pins.addr == la)
				dq[7] = ~ld[7];
			if (ers && !susp)
				dq[7] = 0;
			if (prog || (ers && !susp))
				dq[6] = tgl;
			if (susp && sec(pins.addr) == es)
				dq[2] = tgl;
			lastq = dq;
		end
	end
	assign busy_pull = prog || (ers && !susp);
endmodule : fpc_flash_model

// *** test_flash_program_erase_control.sv ***
// self-checking bench for the flash program/erase controller
`timescale 1ns/10ps
module test_flash_program_erase_control
	import fpc_pkg::*;
;
	localparam logic [18:0] S1 = 19'h18000;
	localparam logic [18:0] S2 = 19'h20000;
	localparam logic [15:0] M  = 16'h02FE;
	logic        clk = 0, arst_n = 0, en = 1, hv = 0;
	logic [3:0]  reg_addr = '0;
	logic [15:0] reg_wdata = '0, reg_rdata, dq_i, pd;
	logic        reg_wr = 0, reg_rd = 0, rd_chk = 0, chk_q = 0;
	logic        busy_pull, fl_rst_n, fl_hv;
	logic [18:0] pa;
	fpc_pins_t   flash;
	logic [15:0] exp_q[$], msk_q[$];
	int          err_total = 0, samples_checked = 0;
	wire         rdy_line = ~busy_pull; // pulled up when released

	fpc_flash_ctrl #(.PWRON_CYCLES(50), .POLL_CYCLES(5000)) u_dut (
		.clk(clk), .arst_n(arst_n), .en(en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .flash(flash), .flash_dq_i(dq_i),
		.flash_reset_n(fl_rst_n), .flash_hv_override(fl_hv),
		.flash_rdy_i(rdy_line));
	fpc_flash_model u_flash (.pins(flash), .reset_n(fl_rst_n), .hv(fl_hv),
		.dq(dq_i), .busy_pull(busy_pull));

	initial
		forever
			#2 clk = ~clk;

	always @(posedge clk)
	begin
		if (chk_q && exp_q.size() > 0)
		begin : cmp
			logic [15:0] e, m;
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			samples_checked++;
			if ((reg_rdata & m) !== e)
			begin
				err_total++;
				$display("MISMATCH reg_rdata exp %h seen %h", e, reg_rdata & m);
			end
		end
		chk_q <= reg_rd && rd_chk;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic acc(bit w, logic [3:0] a, logic [15:0] d, bit c);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		rd_chk <= c;
		@(posedge clk);
		reg_wr <= 0;
		reg_rd <= 0;
		@(posedge clk);
	endtask : acc
	task automatic chk(logic [3:0] a, logic [15:0] e, logic [15:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		acc(0, a, '0, 1);
	endtask : chk
	task automatic st(logic [15:0] e, logic [15:0] m);
		chk(REG_STATUS, e, m);
		acc(1, REG_STATUS, {5'h0, ST_W1C_MASK}, 0);
	endtask : st
	task automatic hang(string what);
		err_total++;
		$display("MISMATCH %s exp done seen timeout", what);
		stop_test();
	endtask : hang
	task automatic idle();
		for (int n = 0; n < 3000; n++)
		begin
			acc(0, REG_STATUS, '0, 0);
			if (reg_rdata[ST_BUSY] === 1'b0)
				return;
		end
		hang("busy");
	endtask : idle
	task automatic wait_flash();
		for (int n = 0; n < 400 && busy_pull !== 1'b1; n++)
			@(posedge clk);
		if (busy_pull !== 1'b1)
			hang("flash_busy");
	endtask : wait_flash
	task automatic op(logic [3:0] o, logic [18:0] a, logic [15:0] d, bit w);
		acc(1, REG_CTRL, {a[18:16], 12'h0, hv}, 0);
		acc(1, REG_ADDR, a[15:0], 0);
		acc(1, REG_DATA, d, 0);
		acc(1, REG_STATUS, {5'h0, ST_W1C_MASK}, 0);
		acc(1, REG_CMD, {12'h0, o}, 0);
		if (w)
			idle();
	endtask : op
	task automatic rd_back(logic [18:0] a, logic [15:0] e);
		op(OP_READ, a, '0, 1);
		chk(REG_RDATA, e, 16'hFFFF);
	endtask : rd_back

	initial
	begin
		void'($urandom(31281));
		repeat (2) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		op(OP_PROGRAM, S1, 16'h0000, 1);
		st(16'h0004, M);
		chk(4'hF, 16'h0000, 16'hFFFF);
		repeat (60) @(posedge clk);
		chk(REG_STATUS, 16'h0100, 16'h0100);
		pd = 16'($urandom) & 16'hFFFE;
		pa = S1 | 19'($urandom % 32768);
		op(OP_PROGRAM, pa, pd, 1);
		st(16'h0002, M);
		rd_back(pa, pd);
		op(OP_PROGRAM, pa, ~pd, 1);
		st(16'h0012, M);
		rd_back(pa, 16'h0000);
		op(OP_SECT_ERASE, pa, '0, 1);
		st(16'h0002, M);
		rd_back(pa, 16'hFFFF);
		op(OP_LOCKOUT, S1, '0, 1);
		op(OP_LOCK_QUERY, S1, '0, 1);
		st(16'h0022, M);
		op(OP_LOCK_QUERY, S2, '0, 1);
		st(16'h0002, M);
		op(OP_PROGRAM, pa, pd, 1);
		st(16'h0012, M);
		hv = 1;
		op(OP_PROGRAM, pa, pd, 1);
		st(16'h0002, M);
		hv = 0;
		rd_back(pa, pd);
		// suspend needs the erase really running in the device
		op(OP_PROGRAM, S2 | 19'h5, pd, 1);
		op(OP_SECT_ERASE, S2, '0, 0);
		wait_flash();
		op(OP_SUSPEND, '0, '0, 1);
		st(16'h0040, 16'h0044);
		op(OP_SECT_ERASE, S1, '0, 1);
		st(16'h0004, 16'h0004);
		op(OP_READ, S2, '0, 1);
		st(16'h0200, 16'h0200);
		op(OP_PROGRAM, 19'h08000, pd, 1);
		st(16'h0002, 16'h0012);
		op(OP_RESUME, S2, '0, 1);
		st(16'h0002, 16'h0042);
		rd_back(S2 | 19'h5, 16'hFFFF);
		op(OP_ID_EXIT, '0, '0, 1);
		st(16'h0002, M);
		op(4'hA, '0, '0, 1);
		st(16'h0004, M);
		op(OP_CHIP_ERASE, '0, '0, 1);
		st(16'h0002, M);
		rd_back(pa, pd);
		rd_back(19'h08000, 16'hFFFF);
		en <= 0;
		acc(1, REG_DATA, 16'h1234, 0);
		en <= 1;
		chk(REG_DATA, 16'h0000, 16'hFFFF);
		op(OP_PROGRAM, S2, pd, 0);
		wait_flash();
		op(OP_SECT_ERASE, S2, '0, 0);
		st(16'h0004, 16'h0004);
		op(OP_RESET, '0, '0, 1);
		st(16'h0080, 16'h0080);
		stop_test();
	end
endmodule : test_flash_program_erase_control
